// ### logic/eeprom_pkg.sv
/*
 * Shared constants, types and helper functions for the serial EEPROM port.
 * Assumes a 10 MHz system clock and a master that supplies its own serial clock.
 */
package eeprom_pkg;

    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SELECT_LOW_MIN_NS = 250;
    localparam logic [2:0] SELECT_LOW_CYCLES =
        3'((SELECT_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned PROGRAM_TIME_US = 2000;
    localparam int unsigned PROGRAM_CYCLES = PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;

    localparam int unsigned MEM_BYTES = 256;
    localparam logic [4:0] OP_BITS = 5'h02;
    localparam logic [4:0] ADDR_BITS_X8 = 5'h09;
    localparam logic [4:0] ADDR_BITS_X16 = 5'h08;
    localparam logic [4:0] DATA_BITS_X8 = 5'h08;
    localparam logic [4:0] DATA_BITS_X16 = 5'h10;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] EMPTY_BYTE = 8'h00;

    localparam logic [1:0] OP_SPECIAL = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_ENABLE = 2'h3;

    typedef enum logic [1:0] {
        VARIANT_SELECTABLE,
        VARIANT_X8,
        VARIANT_X16
    } variant_t;

    typedef enum logic [2:0] {
        LINK_WAIT_START,
        LINK_OPCODE,
        LINK_ADDR,
        LINK_DATA,
        LINK_READ,
        LINK_DONE
    } link_state_t;

    typedef enum logic [1:0] {
        PROG_IDLE,
        PROG_ARMED,
        PROG_BUSY
    } prog_state_t;

    function automatic logic [4:0] addr_bits(input logic wide);
        addr_bits = wide ? ADDR_BITS_X16 : ADDR_BITS_X8;
    endfunction : addr_bits

    function automatic logic [4:0] data_bits(input logic wide);
        data_bits = wide ? DATA_BITS_X16 : DATA_BITS_X8;
    endfunction : data_bits

    // The two leading address bits pick the variant of the special opcode.
    function automatic logic [1:0] special_code(input logic [8:0] addr, input logic wide);
        special_code = wide ? addr[7:6] : addr[8:7];
    endfunction : special_code

endpackage : eeprom_pkg

// ### logic/bit_sync.sv
/*
 * Two-stage level synchroniser with a synchronous reset.
 * Assumes the input is a level that stays put for several destination clocks.
 */
`timescale 1ns/100ps
module bit_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_reg;

    // The first stage feeds only the second one.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : bit_sync

// ### logic/program_timer.sv
/*
 * Self-timed programming interval counter on the system clock.
 * Assumes start is a one-cycle pulse that only comes while the timer is idle.
 */
`timescale 1ns/100ps
module program_timer #(
    parameter int unsigned CYCLES = 20000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [31:0] count_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= 32'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            count_reg <= 32'(CYCLES - 1);
            busy <= 1'b1;
            done <= 1'b0;
        end else if (busy && count_reg == 32'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
        end else begin
            count_reg <= busy ? count_reg - 32'h1 : count_reg;
            done <= 1'b0;
        end
    end
endmodule : program_timer

// ### logic/eeprom_serial_port.sv
/*
 * Serial pin side of a small three-wire EEPROM: instruction shifter on the
 * master's serial clock, programming control and storage on the system clock.
 * Assumes select, serial clock and serial input come straight from the master.
 */
// How it works
// R1: Select high selects the device; select low deselects it into standby.
// R2: A running programming cycle completes whatever select does meanwhile.
// R3: The master keeps select low at least 250 ns between instructions.
// R4: Select low holds the instruction control logic in reset.
// R5: Opcode, address and data bits are sampled on rising serial clock edges.
// R6: Read data bits are launched on rising serial clock edges.
// R7: The serial clock may pause at either level; state is kept meanwhile.
// R8: The serial clock is ignored while select is low.
// R9: Without a start bit, clock edges leave the device waiting for start.
// R10: Programming is timed internally and needs no serial clock edges.
// R11: The master supplies every opcode, address and data bit after start.
// R12: After a full instruction, clock and input are ignored until reselect.
// R13: The master sends start, opcode, address and data with the clock.
// R14: After programming starts, reselect after the minimum low time shows status.
// R15: Select low through the whole cycle shows no status; output stays off.
// R16: Status checked after the cycle reads high for ready.
// R17: A start bit followed by select low removes the status indication.
// R18: Width select high gives 16-bit words, low gives 8-bit words.
// R19: Fixed-width builds ignore the width select input.
// R20: While programming runs, the status output reads low for busy.
// R21: Read gives a zero bit, then words from sequential addresses.
// R22: Programming is disabled at power-up until the enable command runs.
// R23: Start is the first rising edge with serial input high under select.
`timescale 1ns/100ps
module eeprom_serial_port #(
    parameter eeprom_pkg::variant_t VARIANT = eeprom_pkg::VARIANT_SELECTABLE,
    parameter int unsigned PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic select,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic word_width_select,
    output logic serial_out,
    output logic serial_out_oe_n
);
    import eeprom_pkg::*;

    logic [7:0] mem_reg [0:MEM_BYTES-1];

    // Link domain.
    link_state_t state_reg;
    logic [4:0] count_reg;
    logic [1:0] op_reg;
    logic [8:0] addr_reg;
    logic [15:0] data_reg;
    logic [15:0] read_word_reg;
    logic out_bit_reg;
    logic read_drive_reg;
    logic cmd_toggle_reg;
    logic start_toggle_reg;
    logic [1:0] cmd_op_reg;
    logic [8:0] cmd_addr_reg;
    logic [15:0] cmd_data_reg;
    logic cmd_wide_reg;
    logic link_rst;
    logic busy_link;
    logic width_sync;
    logic wide;
    logic [8:0] addr_in;
    logic [15:0] data_in;
    logic [8:0] fetch_addr;
    logic [15:0] fetch_word;
    logic last_addr;
    logic last_data;
    logic needs_data;
    logic issue;
    logic start_now;

    // System clock domain.
    prog_state_t prog_reg;
    logic sel_sync;
    logic sel_prev_reg;
    logic cmd_sync;
    logic cmd_seen_reg;
    logic start_sync;
    logic start_seen_reg;
    logic start_flag_reg;
    logic enable_reg;
    logic pending_reg;
    logic show_reg;
    logic ready_reg;
    logic [2:0] low_count_reg;
    logic [1:0] p_op_reg;
    logic [8:0] p_addr_reg;
    logic [15:0] p_data_reg;
    logic p_wide_reg;
    logic [1:0] cmd_sub;
    logic cmd_evt;
    logic start_evt;
    logic timer_start;
    logic timer_busy;
    logic timer_done;

    bit_sync #(.RESET_VAL(1'b1)) u_link_rst (
        .clk(serial_clk), .rst(1'b0), .d(sys_rst), .q(link_rst)
    );
    bit_sync u_busy_link (
        .clk(serial_clk), .rst(link_rst), .d(timer_busy), .q(busy_link)
    );
    bit_sync u_width (
        .clk(serial_clk), .rst(link_rst), .d(word_width_select), .q(width_sync)
    );
    bit_sync u_sel (
        .clk(clk), .rst(sys_rst), .d(select), .q(sel_sync)
    );
    bit_sync u_cmd (
        .clk(clk), .rst(sys_rst), .d(cmd_toggle_reg), .q(cmd_sync)
    );
    bit_sync u_start (
        .clk(clk), .rst(sys_rst), .d(start_toggle_reg), .q(start_sync)
    );

    program_timer #(.CYCLES(PROGRAM_CYCLES)) u_timer (
        .clk(clk), .sys_rst(sys_rst), .start(timer_start),
        .busy(timer_busy), .done(timer_done)
    );

    always_comb begin
        case (VARIANT)
            VARIANT_X8: wide = 1'b0; // [R19]
            VARIANT_X16: wide = 1'b1; // [R19]
            default: wide = width_sync; // [R18]
        endcase
    end

    assign addr_in = {addr_reg[7:0], serial_in};
    assign data_in = {data_reg[14:0], serial_in};
    assign last_addr = state_reg == LINK_ADDR && count_reg == addr_bits(wide) - 5'h01;
    assign last_data = state_reg == LINK_DATA && count_reg == data_bits(wide) - 5'h01;
    assign needs_data = op_reg == OP_WRITE ||
        (op_reg == OP_SPECIAL && special_code(addr_in, wide) == SUB_WRITE_ALL);
    // New instructions other than reads are refused while the array is still being programmed.
    assign issue = !busy_link && ((last_addr && op_reg != OP_READ && !needs_data) ||
        last_data); // [R11]
    assign start_now = state_reg == LINK_WAIT_START && serial_in; // [R23]

    // The array only changes at the end of a programming cycle, so a read
    // outside that moment sees settled words.
    always_comb begin
        fetch_addr = state_reg == LINK_ADDR ? addr_in : addr_reg + 9'h001; // [R21]
        if (wide) begin
            fetch_word = {mem_reg[{fetch_addr[6:0], 1'b0}], mem_reg[{fetch_addr[6:0], 1'b1}]};
        end else begin
            fetch_word = {mem_reg[fetch_addr[7:0]], EMPTY_BYTE};
        end
    end

    // Select low resets the shifter at once, and no serial edge is seen then.
    always_ff @(posedge serial_clk or negedge select) begin // [R1] [R4] [R8]
        if (!select) begin
            state_reg <= LINK_WAIT_START;
            count_reg <= 5'h00;
            out_bit_reg <= 1'b0;
            read_drive_reg <= 1'b0;
        end else begin
            case (state_reg)
                LINK_WAIT_START: begin
                    if (serial_in) begin // [R9] [R23]
                        state_reg <= LINK_OPCODE;
                        count_reg <= 5'h00;
                    end
                end
                LINK_OPCODE: begin
                    count_reg <= count_reg == OP_BITS - 5'h01 ? 5'h00 : count_reg + 5'h01;
                    if (count_reg == OP_BITS - 5'h01) begin
                        state_reg <= LINK_ADDR;
                    end
                end
                LINK_ADDR: begin
                    count_reg <= last_addr ? 5'h00 : count_reg + 5'h01;
                    if (last_addr && op_reg == OP_READ) begin
                        state_reg <= LINK_READ;
                        out_bit_reg <= 1'b0; // [R21]
                        read_drive_reg <= 1'b1; // [R6]
                    end else if (last_addr) begin
                        state_reg <= needs_data ? LINK_DATA : LINK_DONE;
                    end
                end
                LINK_DATA: begin
                    count_reg <= count_reg + 5'h01;
                    if (last_data) begin
                        state_reg <= LINK_DONE;
                    end
                end
                LINK_READ: begin
                    out_bit_reg <= read_word_reg[15]; // [R6]
                    count_reg <= count_reg == data_bits(wide) - 5'h01 ?
                        5'h00 : count_reg + 5'h01;
                end
                LINK_DONE: state_reg <= LINK_DONE; // [R12]
                default: state_reg <= LINK_WAIT_START;
            endcase
        end
    end

    // Shift registers keep their contents across a paused clock.
    always_ff @(posedge serial_clk) begin // [R5] [R7]
        if (state_reg == LINK_OPCODE) begin
            op_reg <= {op_reg[0], serial_in};
        end
        if (state_reg == LINK_ADDR) begin
            addr_reg <= addr_in;
        end else if (state_reg == LINK_READ && count_reg == data_bits(wide) - 5'h01) begin
            addr_reg <= fetch_addr; // [R21]
        end
        if (state_reg == LINK_DATA) begin
            data_reg <= data_in;
        end
        if (last_addr || (state_reg == LINK_READ && count_reg == data_bits(wide) - 5'h01)) begin
            read_word_reg <= fetch_word;
        end else if (state_reg == LINK_READ) begin
            read_word_reg <= {read_word_reg[14:0], 1'b0};
        end
    end

    // Held command words stay stable until the next instruction, which cannot
    // finish before the system clock has taken the toggle.
    always_ff @(posedge serial_clk) begin
        if (link_rst) begin
            cmd_toggle_reg <= 1'b0;
            start_toggle_reg <= 1'b0;
        end else begin
            if (select && issue) begin
                cmd_toggle_reg <= ~cmd_toggle_reg;
                cmd_op_reg <= op_reg;
                cmd_addr_reg <= last_data ? addr_reg : addr_in;
                cmd_data_reg <= data_in;
                cmd_wide_reg <= wide;
            end
            if (select && start_now) begin
                start_toggle_reg <= ~start_toggle_reg;
            end
        end
    end

    assign cmd_evt = cmd_sync != cmd_seen_reg;
    assign start_evt = start_sync != start_seen_reg;
    assign cmd_sub = special_code(cmd_addr_reg, cmd_wide_reg);
    assign timer_start = prog_reg == PROG_ARMED && !sel_sync;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_seen_reg <= cmd_sync;
            start_seen_reg <= start_sync;
            sel_prev_reg <= 1'b0;
        end else begin
            cmd_seen_reg <= cmd_sync;
            start_seen_reg <= start_sync;
            sel_prev_reg <= sel_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prog_reg <= PROG_IDLE;
            enable_reg <= 1'b0; // [R22]
        end else begin
            case (prog_reg)
                PROG_IDLE: begin
                    if (cmd_evt && cmd_op_reg == OP_SPECIAL && cmd_sub == SUB_ENABLE) begin
                        enable_reg <= 1'b1; // [R22]
                    end else if (cmd_evt && cmd_op_reg == OP_SPECIAL &&
                        cmd_sub == SUB_DISABLE) begin
                        enable_reg <= 1'b0;
                    end else if (cmd_evt && enable_reg) begin // [R22]
                        prog_reg <= PROG_ARMED;
                        p_op_reg <= cmd_op_reg;
                        p_addr_reg <= cmd_addr_reg;
                        p_data_reg <= cmd_data_reg;
                        p_wide_reg <= cmd_wide_reg;
                    end
                end
                PROG_ARMED: prog_reg <= timer_start ? PROG_BUSY : PROG_ARMED;
                PROG_BUSY: prog_reg <= timer_done ? PROG_IDLE : PROG_BUSY; // [R2] [R10]
                default: prog_reg <= PROG_IDLE;
            endcase
        end
    end

    // All-array operations touch every byte; the others touch one word.
    always_ff @(posedge clk) begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            if (timer_done && (p_op_reg == OP_SPECIAL ||
                (p_wide_reg ? 7'(i >> 1) == p_addr_reg[6:0] : 8'(i) == p_addr_reg[7:0]))) begin
                if (p_op_reg == OP_ERASE || p_op_reg == OP_SPECIAL &&
                    special_code(p_addr_reg, p_wide_reg) == SUB_ERASE_ALL) begin
                    mem_reg[i] <= ERASED_BYTE;
                end else if (p_wide_reg) begin
                    mem_reg[i] <= (i % 2 == 1) ? p_data_reg[7:0] : p_data_reg[15:8];
                end else begin
                    mem_reg[i] <= p_data_reg[7:0];
                end
            end
        end
    end

    // Status is offered only once a cycle has been started, and only after a
    // low select of the minimum length, since shorter gaps are not instructions.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_count_reg <= 3'h0;
            start_flag_reg <= 1'b0;
            pending_reg <= 1'b0;
            show_reg <= 1'b0;
            ready_reg <= 1'b1;
        end else begin
            low_count_reg <= sel_sync ? 3'h0 :
                (low_count_reg < SELECT_LOW_CYCLES ? low_count_reg + 3'h1 : low_count_reg);
            ready_reg <= !timer_busy && prog_reg != PROG_ARMED; // [R16] [R20]
            if (timer_start) begin
                pending_reg <= 1'b1;
                start_flag_reg <= 1'b0;
            end else if (!sel_sync && (start_flag_reg || start_evt)) begin
                pending_reg <= 1'b0; // [R17]
                start_flag_reg <= 1'b0;
            end else if (start_evt) begin
                start_flag_reg <= 1'b1;
            end
            if (!sel_sync) begin
                show_reg <= 1'b0; // [R15]
            end else if (!sel_prev_reg && pending_reg && low_count_reg >= SELECT_LOW_CYCLES) begin
                show_reg <= 1'b1; // [R3] [R14]
            end
        end
    end

    // The pin is a single driver shared by read data and status; read data wins.
    assign serial_out = read_drive_reg ? out_bit_reg : ready_reg; // [R16] [R20]
    assign serial_out_oe_n = !(read_drive_reg || show_reg); // [R15]

endmodule : eeprom_serial_port

// ### verification/eeprom_serial_port_monitor.sv
/*
 * Assertion checker bound to the serial EEPROM port.
 * Assumes width select is steady during an instruction.
 */
`timescale 1ns/100ps
module eeprom_serial_port_monitor #(
    parameter eeprom_pkg::variant_t VARIANT = eeprom_pkg::VARIANT_SELECTABLE,
    parameter int unsigned PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic select,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic word_width_select,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    import eeprom_pkg::*;

    logic [5:0] cnt_reg;
    logic [1:0] op_reg;
    logic [7:0] busy_cnt_reg;
    logic wide;
    logic [5:0] dummy_pos;

    assign wide = (VARIANT == VARIANT_X16) || (VARIANT == VARIANT_SELECTABLE && word_width_select);
    assign dummy_pos = wide ? 6'h0b : 6'h0c;

    // Select low clears the count, as it clears the shifter.
    always_ff @(posedge serial_clk or negedge select) begin
        if (!select) begin
            cnt_reg <= 6'h00;
        end else if (cnt_reg == 6'h00) begin
            cnt_reg <= {5'h00, serial_in};
        end else if (cnt_reg != 6'h3f) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge serial_clk or negedge select) begin
        if (!select) begin
            op_reg <= 2'h0;
        end else if (cnt_reg == 6'h01 || cnt_reg == 6'h02) begin
            op_reg <= {op_reg[0], serial_in};
        end
    end

    // Slack covers zero read bits held by a paused clock.
    always_ff @(posedge clk) begin
        if (sys_rst || !select || serial_out_oe_n || serial_out) begin
            busy_cnt_reg <= 8'h00;
        end else if (busy_cnt_reg != 8'hff) begin
            busy_cnt_reg <= busy_cnt_reg + 8'h01;
        end
    end

    sequence s_ready_idle;
        select && serial_out && !serial_out_oe_n && cnt_reg == 6'h00;
    endsequence

    sequence s_still_idle;
        select && cnt_reg == 6'h00;
    endsequence

    sequence s_long_deselect;
        !select [*5];
    endsequence

    AST_RESET_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) && !select |-> serial_out_oe_n)
        else $error("output driven after reset");
    AST_DESELECT_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(select) |-> ##[0:4] serial_out_oe_n)
        else $error("output held after deselect");
    AST_DESELECT_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
        s_long_deselect |-> serial_out_oe_n)
        else $error("output driven while deselected");
    AST_OE_NEEDS_SELECT: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(serial_out_oe_n) |-> $past(select) && $past(select, 2))
        else $error("output enabled unselected");
    AST_READY_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
        s_ready_idle ##1 s_still_idle |-> serial_out && !serial_out_oe_n)
        else $error("ready lost while idle");
    AST_BUSY_BOUNDED: assert property (@(posedge clk) disable iff (sys_rst)
        busy_cnt_reg <= 8'(PROGRAM_CYCLES + 8))
        else $error("busy status shown too long");
    AST_READ_DUMMY: assert property (@(posedge serial_clk) disable iff (sys_rst || !select)
        op_reg == OP_READ && cnt_reg == dummy_pos |-> !serial_out_oe_n && !serial_out)
        else $error("missing leading zero of read");
    AST_READ_DRIVES: assert property (@(posedge serial_clk) disable iff (sys_rst || !select)
        op_reg == OP_READ && cnt_reg > dummy_pos |-> !serial_out_oe_n)
        else $error("read data not driven");
endmodule : eeprom_serial_port_monitor

bind eeprom_serial_port eeprom_serial_port_monitor #(
    .VARIANT(VARIANT),
    .PROGRAM_CYCLES(PROGRAM_CYCLES)
) u_monitor (
    .clk(clk),
    .sys_rst(sys_rst),
    .select(select),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .word_width_select(word_width_select),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n)
);

// ### verification/serial_master_model.sv
/*
 * Behavioural serial master: select, serial clock, serial input.
 * Assumes one task at a time; the clock stands still between tasks.
 */
`timescale 1ns/100ps
module serial_master_model (
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    output logic select,
    output logic serial_clk,
    output logic serial_in
);
    initial begin
        select = 1'b0;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end

    // Edges with select low, to be ignored.
    task automatic spin(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in = ~serial_in;
            #16 serial_clk = 1'b1;
            #16 serial_clk = 1'b0;
        end
    endtask : spin

    // Output is sampled just before the next edge, once settled.
    task automatic shift(input logic [31:0] bits, input int n, input int pause_at,
            output logic [31:0] seen);
        seen = 32'h0000_0000;
        select = 1'b1;
        #300;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = bits[i];
            if (i == pause_at) #500;
            #16 serial_clk = 1'b1;
            #15 seen = {seen[30:0], serial_out};
            #1 serial_clk = 1'b0;
        end
        serial_in = ~serial_in;
    endtask : shift

    task automatic deselect();
        select = 1'b0;
        #400;
    endtask : deselect

    task automatic reselect();
        select = 1'b1;
    endtask : reselect
endmodule : serial_master_model

// ### verification/serial_eeprom_pin_interface_test.sv
/*
 * Self-checking bench for the serial EEPROM port and a model master.
 * Assumes a short programming time: each cycle is 20 clocks.
 */
`timescale 1ns/100ps
module serial_eeprom_pin_interface_test;
    import eeprom_pkg::*;

    logic clk;
    logic sys_rst;
    logic word_width_select;
    logic select;
    logic serial_clk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;
    logic [31:0] seen;
    int n_errors = 0;
    int check_count = 0;

    eeprom_serial_port #(.PROGRAM_CYCLES(20)) DUT (
        .clk(clk),
        .sys_rst(sys_rst),
        .select(select),
        .serial_clk(serial_clk),
        .serial_in(serial_in),
        .word_width_select(word_width_select),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n)
    );

    serial_master_model master (
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n),
        .select(select),
        .serial_clk(serial_clk),
        .serial_in(serial_in)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic send(input logic [31:0] bits, input int n, input int pause_at = -1);
        master.shift(bits, n, pause_at, seen);
        master.deselect();
    endtask : send

    task automatic wake();
        master.reselect();
        repeat (6) @(negedge clk);
    endtask : wake

    // Programs, then expects busy and later ready on reselect.
    task automatic prog(input logic [31:0] bits, input int n);
        int i;
        send(bits, n);
        wake();
        check({15'h0, serial_out_oe_n, serial_out}, 17'h0);
        for (i = 0; i < 60; i++) begin
            if (serial_out_oe_n === 1'b0 && serial_out === 1'b1) break;
            @(negedge clk);
        end
        if (i == 60) begin
            n_errors++;
            test_done();
        end
        check({15'h0, serial_out_oe_n, serial_out}, 17'h1);
        master.deselect();
    endtask : prog

    task automatic t_powerup();
        check({16'h0, serial_out_oe_n}, 17'h1);
        send({1'b1, OP_WRITE, 9'h003, 8'h5a}, 20);
        wake();
        check({16'h0, serial_out_oe_n}, 17'h1);
        master.deselect();
        $display("test powerup done");
    endtask : t_powerup

    task automatic t_special();
        send({1'b1, OP_SPECIAL, SUB_ENABLE, 7'h00}, 12);
        prog({1'b1, OP_SPECIAL, SUB_WRITE_ALL, 7'h00, 8'h77}, 20);
        send({1'b1, OP_READ, 9'h009, 16'h0000}, 28);
        check(seen[16:0], {1'b0, 8'h77, 8'h77});
        prog({1'b1, OP_SPECIAL, SUB_ERASE_ALL, 7'h00}, 12);
        send({1'b1, OP_READ, 9'h0ff, 16'h0000}, 28);
        check(seen[16:0], {1'b0, 8'hff, 8'hff});
        $display("test special done");
    endtask : t_special

    task automatic t_write_read();
        prog({1'b1, OP_WRITE, 9'h005, 8'ha5}, 20);
        prog({1'b1, OP_WRITE, 9'h006, 8'h3c, 4'hb}, 24);
        wake();
        check({15'h0, serial_out_oe_n, serial_out}, 17'h1);
        master.deselect();
        send({1'b1}, 1);
        wake();
        check({16'h0, serial_out_oe_n}, 17'h1);
        master.deselect();
        send({3'h0, 1'b1, OP_READ, 9'h005, 16'h0000}, 31, 10);
        check(seen[16:0], {1'b0, 8'ha5, 8'h3c});
        $display("test write read done");
    endtask : t_write_read

    task automatic t_erase_quiet();
        send({1'b1, OP_ERASE, 9'h005}, 12);
        repeat (10) @(negedge clk);
        check({16'h0, serial_out_oe_n}, 17'h1);
        repeat (30) @(negedge clk);
        send({1'b1, OP_READ, 9'h005, 16'h0000}, 28);
        check(seen[16:0], {1'b0, 8'hff, 8'h3c});
        $display("test erase done");
    endtask : t_erase_quiet

    task automatic t_disable();
        send({1'b1, OP_SPECIAL, SUB_DISABLE, 7'h00}, 12);
        send({1'b1, OP_WRITE, 9'h006, 8'h00}, 20);
        repeat (30) @(negedge clk);
        send({1'b1, OP_READ, 9'h006, 16'h0000}, 28);
        check(seen[16:0], {1'b0, 8'h3c, 8'hff});
        $display("test disable done");
    endtask : t_disable

    task automatic t_wide();
        word_width_select = 1'b1;
        repeat (4) @(negedge clk);
        master.spin(4);
        send({1'b1, OP_SPECIAL, SUB_ENABLE, 6'h00}, 11);
        prog({1'b1, OP_WRITE, 8'h02, 16'h1234}, 27);
        send({1'b1, OP_READ, 8'h02, 16'h0000}, 27);
        check(seen[16:0], {1'b0, 16'h1234});
        @(negedge clk);
        word_width_select = 1'b0;
        repeat (4) @(negedge clk);
        send({1'b1, OP_READ, 9'h004, 16'h0000}, 28);
        check(seen[16:0], {1'b0, 8'h12, 8'h34});
        $display("test width done");
    endtask : t_wide

    // Serial clock ticks in reset so the link side clears too.
    initial begin
        sys_rst = 1'b1;
        word_width_select = 1'b0;
        fork
            master.spin(6);
            repeat (10) @(negedge clk);
        join
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        t_powerup();
        t_special();
        t_write_read();
        t_erase_quiet();
        t_disable();
        t_wide();
        test_done();
    end
endmodule : serial_eeprom_pin_interface_test
